// ---- logic/pmbus_bank_map.vh ----
`ifndef PMBUS_BANK_MAP_VH
`define PMBUS_BANK_MAP_VH

// Command codes
`define CMD_CLEAR_STATUS 8'h03
`define CMD_TEMP_STATUS 8'h7D
`define CMD_COMM_STATUS 8'h7E
`define CMD_VIN_READ 8'h88
`define CMD_VOUT_READ 8'h8B
`define CMD_IOUT_READ 8'h8C
`define CMD_TEMP_READ 8'h8D
`define CMD_TYPE_LOCK 8'hD0
`define CMD_VOUT_GAIN 8'hD1
`define CMD_VOUT_OFS 8'hD2
`define CMD_VIN_GAIN 8'hD3
`define CMD_VIN_OFS 8'hD4
`define CMD_IOUT_GAIN 8'hD6
`define CMD_IOUT_OFS 8'hD7
`define CMD_FW_REV 8'hDB
`define CMD_PIN_CFG 8'hE0
`define CMD_ONOFF_LOGIC 8'hE1
`define CMD_OUTPUT_OK_SIGNAL_POL 8'hE2

// Alert response address
`define ARA_ADDRESS 7'h0C

// Field positions
`define TEMP_FAULT_BIT 7
`define TEMP_WARN_BIT 6
`define COMM_CMD_BIT 7
`define COMM_DATA_BIT 6
`define COMM_PEC_BIT 5
`define NAME_MSB 7
`define NAME_LSB 2
`define LOCK_BIT 1
`define ARA_BIT 4
`define PIN_MSB 3
`define COMBINE_BIT 1
`define SEC_POL_BIT 0
`define OK_POL_BIT 0

// Reset values
`define LOCK_RST 1'h1
`define PIN_CFG_RST 8'h00
`define ONOFF_LOGIC_RST 8'h00
`define OK_POL_RST 8'h01
`define GAIN_RST 16'h2000
`define VOUT_OFS_RST 16'hA000
`define LIN_OFS_RST 16'hE800

// Calibration limits and exponents
`define GAIN_MIN 16'h1999
`define GAIN_MAX 16'h2666
`define EXP_VOUT_OFS 5'h14
`define EXP_LIN_OFS 5'h1D

// Pin assignment codes
`define PIN_SEC_ONOFF 4'h0
`define PIN_TRIM 4'h1
`define PIN_TRIM_AUX 4'h2

// Command length classes
`define LEN_NONE 2'h0
`define LEN_BYTE 2'h1
`define LEN_WORD 2'h2
`define LEN_SEND 2'h3

`endif

// ---- logic/pin_sync3.v ----
`timescale 1ns/1ns
`default_nettype none

module pin_sync3 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire [WIDTH-1:0] pin,
    output reg [WIDTH-1:0] level
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;
reg [WIDTH-1:0] stage3;

// A bit follows only where the second and third stage agree
always @(posedge clk or posedge rst) begin
    if (rst) begin
        stage1 <= RST_VAL;
        stage2 <= RST_VAL;
        stage3 <= RST_VAL;
        level <= RST_VAL;
    end else if (ce) begin
        stage1 <= pin;
        stage2 <= stage1;
        stage3 <= stage2;
        level <= (stage2 & stage3) | (level & (stage2 | stage3));
    end
end

endmodule // pin_sync3

`default_nettype wire

// ---- logic/pec_crc8.v ----
`timescale 1ns/1ns
`default_nettype none

module pec_crc8 (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire clear,
    input wire feed,
    input wire [7:0] data,
    output reg [7:0] crc
);

// CRC-8, polynomial x^8 + x^2 + x + 1, MSB first
function [7:0] crc8_step;
    input [7:0] acc;
    input [7:0] din;
    reg [7:0] c;
    integer i;
    begin
        c = acc ^ din;
        for (i = 0; i < 8; i = i + 1) begin
            c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
        end
        crc8_step = c;
    end
endfunction

always @(posedge clk or posedge rst) begin
    if (rst) begin
        crc <= 8'h00;
    end else if (ce) begin
        if (clear) begin
            crc <= 8'h00;
        end else if (feed) begin
            crc <= crc8_step(crc, data);
        end
    end
end

endmodule // pec_crc8

`default_nettype wire

// ---- logic/pmbus_status_mfr_config_bank.v ----
`timescale 1ns/1ns
`default_nettype none
`include "pmbus_bank_map.vh"

// Contract
// - Temp status: bit 7 overtemp fault, bit 6 overtemp warning.
// - Comm status: bit 7 bad command, 6 bad data, 5 checksum error.
// - Status bits latch through reads; only the clear command resets them.
// - Telemetry reads return present measurements.
// - Type register: high byte zero, name 7:2, lock bit 1, bit 0 zero.
// - Lock set refuses calibration writes; lock clear accepts them.
// - Name and lock bits stay writable despite the lock.
// - Gain calibration must lie within its bounds.
// - Firmware revision is read-only.
// - Bit 4 set answers only the alert address while alert is active.
// - Bits 3:0 choose on/off, trim, or trim plus auxiliary on/off.
// - Load-sharing builds accept only pin code zero.
// - Combine bit 1 ANDs secondary on/off with primary; 0 ignores it.
// - Polarity bit 0: 0 enables low, 1 enables high; 7:2 zero.
// - Output-ok polarity bit 0: 0 active low, 1 active high; resets 1.
module pmbus_status_mfr_config_bank #(
    parameter [15:0] FW_REVISION = 16'h0100,
    // Module designation, value arbitrary
    parameter [5:0] MODULE_NAME = 6'h15
) (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire scl_pin,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire [6:0] bus_addr_strap,
    input wire load_share_option,
    input wire alert_active,
    input wire overtemp_fault_event,
    input wire overtemp_warning_event,
    input wire [15:0] vin_meas,
    input wire [15:0] vout_meas,
    input wire [15:0] iout_meas,
    input wire [15:0] temp_meas,
    input wire primary_on_request,
    input wire power_ok,
    input wire trim_control_pin,
    input wire auxiliary_control_pin,
    output reg power_stage_enable,
    output reg output_ok_signal,
    output reg trim_select
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_ADDR = 3'h1;
localparam [2:0] ST_WRX = 3'h2;
localparam [2:0] ST_TX = 3'h3;
localparam [2:0] ST_IGNORE = 3'h4;

localparam [1:0] VERDICT_OK = 2'h0;
localparam [1:0] VERDICT_DATA = 2'h1;
localparam [1:0] VERDICT_RO = 2'h2;

function [1:0] cmd_len;
    input [7:0] code;
    begin
        case (code)
            `CMD_CLEAR_STATUS: cmd_len = `LEN_SEND;
            `CMD_TEMP_STATUS, `CMD_COMM_STATUS, `CMD_PIN_CFG,
            `CMD_ONOFF_LOGIC, `CMD_OUTPUT_OK_SIGNAL_POL: cmd_len = `LEN_BYTE;
            `CMD_VIN_READ, `CMD_VOUT_READ, `CMD_IOUT_READ, `CMD_TEMP_READ,
            `CMD_TYPE_LOCK, `CMD_VOUT_GAIN, `CMD_VOUT_OFS, `CMD_VIN_GAIN,
            `CMD_VIN_OFS, `CMD_IOUT_GAIN, `CMD_IOUT_OFS,
            `CMD_FW_REV: cmd_len = `LEN_WORD;
            default: cmd_len = `LEN_NONE;
        endcase
    end
endfunction

wire [3:0] pins_s;
wire scl_s = pins_s[0];
wire sda_s = pins_s[1];
wire trim_s = pins_s[2];
wire aux_s = pins_s[3];
wire [7:0] crc;

reg scl_d;
reg sda_d;
reg [2:0] state;
reg [3:0] bitcnt;
reg in_ack;
reg master_ack;
reg in_txn;
reg [7:0] shift;
reg [7:0] tx_shift;
reg [1:0] tx_idx;
reg [15:0] rd_word;
reg is_ara;
reg [7:0] cmd;
reg cmd_seen;
reg [1:0] nbytes;
reg [15:0] wdata;
reg [6:0] own_addr;
reg addr_taken;
reg crc_clear;
reg crc_feed;
reg [7:0] crc_byte;
reg ev_cmd;
reg ev_data;
reg ev_pec;
reg clear_req;
reg commit;

reg temp_fault;
reg temp_warn;
reg comm_cmd;
reg comm_data;
reg comm_pec;
reg [5:0] module_name;
reg lock;
reg [15:0] vout_gain;
reg [15:0] vout_ofs;
reg [15:0] vin_gain;
reg [15:0] vin_ofs;
reg [15:0] iout_gain;
reg [15:0] iout_ofs;
reg [7:0] pin_cfg;
reg [7:0] onoff_logic;
reg [7:0] ok_pol;

reg [15:0] rd_mux;
reg [7:0] next_tx;
reg [1:0] verdict;

pin_sync3 #(
    .WIDTH(4),
    .RST_VAL(4'h3)
) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin({auxiliary_control_pin, trim_control_pin, sda_in, scl_pin}),
    .level(pins_s)
);

pec_crc8 u_pec (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .clear(crc_clear),
    .feed(crc_feed),
    .data(crc_byte),
    .crc(crc)
);

wire scl_rise = scl_s & ~scl_d;
wire scl_fall = ~scl_s & scl_d;
wire start_det = scl_s & scl_d & sda_d & ~sda_s;
wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
wire ara_mode = pin_cfg[`ARA_BIT] & alert_active;
wire addr_match = ara_mode ? (shift[7:1] == `ARA_ADDRESS && shift[0])
                           : (shift[7:1] == own_addr);
wire [1:0] cur_len = cmd_len(cmd);
wire pec_ok = (crc == 8'h00);
wire [2:0] len_pec = {1'b0, cur_len} + 3'h1;
wire [3:0] pin_code = pin_cfg[`PIN_MSB:0];

// Read data for the current command
always @* begin
    case (cmd)
        `CMD_TEMP_STATUS: rd_mux = {8'h00, temp_fault, temp_warn,
                                    6'h00};
        `CMD_COMM_STATUS: rd_mux = {8'h00, comm_cmd, comm_data, comm_pec,
                                    5'h00};
        `CMD_VIN_READ: rd_mux = vin_meas;
        `CMD_VOUT_READ: rd_mux = vout_meas;
        `CMD_IOUT_READ: rd_mux = iout_meas;
        `CMD_TEMP_READ: rd_mux = temp_meas;
        `CMD_TYPE_LOCK: rd_mux = {8'h00, module_name, lock, 1'b0};
        `CMD_VOUT_GAIN: rd_mux = vout_gain;
        `CMD_VOUT_OFS: rd_mux = vout_ofs;
        `CMD_VIN_GAIN: rd_mux = vin_gain;
        `CMD_VIN_OFS: rd_mux = vin_ofs;
        `CMD_IOUT_GAIN: rd_mux = iout_gain;
        `CMD_IOUT_OFS: rd_mux = iout_ofs;
        `CMD_FW_REV: rd_mux = FW_REVISION;
        `CMD_PIN_CFG: rd_mux = {8'h00, pin_cfg};
        `CMD_ONOFF_LOGIC: rd_mux = {8'h00, onoff_logic};
        `CMD_OUTPUT_OK_SIGNAL_POL: rd_mux = {8'h00, ok_pol};
        default: rd_mux = 16'hFFFF;
    endcase
end

// Next byte to send: data then checksum, or the own address for an alert reply, then idle ones
always @* begin
    if (is_ara) begin
        next_tx = (tx_idx == 2'h0) ? {own_addr, 1'b0} : 8'hFF;
    end else if (cur_len != `LEN_BYTE && cur_len != `LEN_WORD) begin
        next_tx = 8'hFF;
    end else if (tx_idx == 2'h0) begin
        next_tx = rd_mux[7:0];
    end else if (tx_idx == 2'h1 && cur_len == `LEN_WORD) begin
        next_tx = rd_word[15:8];
    end else if (tx_idx == cur_len) begin
        next_tx = crc;
    end else begin
        next_tx = 8'hFF;
    end
end

// Check a completed write before it may change state
always @* begin
    case (cmd)
        `CMD_TYPE_LOCK, `CMD_ONOFF_LOGIC, `CMD_OUTPUT_OK_SIGNAL_POL:
            verdict = VERDICT_OK;
        `CMD_VOUT_GAIN, `CMD_VIN_GAIN, `CMD_IOUT_GAIN:
            if (lock || wdata < `GAIN_MIN || wdata > `GAIN_MAX) begin
                verdict = VERDICT_DATA;
            end else begin
                verdict = VERDICT_OK;
            end
        `CMD_VOUT_OFS:
            verdict = (lock || wdata[15:11] != `EXP_VOUT_OFS) ?
                VERDICT_DATA : VERDICT_OK;
        `CMD_VIN_OFS, `CMD_IOUT_OFS:
            verdict = (lock || wdata[15:11] != `EXP_LIN_OFS) ?
                VERDICT_DATA : VERDICT_OK;
        `CMD_PIN_CFG:
            if (wdata[`PIN_MSB:0] > `PIN_TRIM_AUX ||
                (load_share_option &&
                 wdata[`PIN_MSB:0] != `PIN_SEC_ONOFF)) begin
                verdict = VERDICT_DATA;
            end else begin
                verdict = VERDICT_OK;
            end
        default: verdict = VERDICT_RO;
    endcase
end

// Link engine
always @(posedge clk or posedge rst) begin
    if (rst) begin
        scl_d <= 1'b1;
        sda_d <= 1'b1;
        sda_out <= 1'b0;
        sda_oe <= 1'b0;
        state <= ST_IDLE;
        bitcnt <= 4'h0;
        in_ack <= 1'b0;
        master_ack <= 1'b0;
        in_txn <= 1'b0;
        shift <= 8'h00;
        tx_shift <= 8'hFF;
        tx_idx <= 2'h0;
        rd_word <= 16'h0000;
        is_ara <= 1'b0;
        cmd <= 8'h00;
        cmd_seen <= 1'b0;
        nbytes <= 2'h0;
        wdata <= 16'h0000;
        own_addr <= 7'h00;
        addr_taken <= 1'b0;
        crc_clear <= 1'b0;
        crc_feed <= 1'b0;
        crc_byte <= 8'h00;
        ev_cmd <= 1'b0;
        ev_data <= 1'b0;
        ev_pec <= 1'b0;
        clear_req <= 1'b0;
        commit <= 1'b0;
    end else if (ce) begin
        crc_clear <= 1'b0;
        crc_feed <= 1'b0;
        ev_cmd <= 1'b0;
        ev_data <= 1'b0;
        ev_pec <= 1'b0;
        clear_req <= 1'b0;
        commit <= 1'b0;
        scl_d <= scl_s;
        sda_d <= sda_s;
        if (!addr_taken) begin
            own_addr <= bus_addr_strap;
            addr_taken <= 1'b1;
        end
        if (start_det) begin
            if (!in_txn) begin
                crc_clear <= 1'b1;
                cmd_seen <= 1'b0;
                nbytes <= 2'h0;
            end
            in_txn <= 1'b1;
            state <= ST_ADDR;
            bitcnt <= 4'h0;
            in_ack <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_det) begin
            state <= ST_IDLE;
            in_txn <= 1'b0;
            in_ack <= 1'b0;
            sda_oe <= 1'b0;
            if (state == ST_WRX && cmd_seen) begin
                if (cur_len == `LEN_SEND) begin
                    if (nbytes == 2'h0) begin
                        clear_req <= 1'b1;
                    end else if (nbytes == 2'h1) begin
                        clear_req <= pec_ok;
                        ev_pec <= ~pec_ok;
                    end else begin
                        ev_data <= 1'b1;
                    end
                end else if (nbytes == 2'h0) begin
                    commit <= 1'b0;
                end else if (nbytes == cur_len ||
                             ({1'b0, nbytes} == len_pec && pec_ok)) begin
                    commit <= (verdict == VERDICT_OK);
                    ev_data <= (verdict == VERDICT_DATA);
                    ev_cmd <= (verdict == VERDICT_RO);
                end else if ({1'b0, nbytes} == len_pec) begin
                    ev_pec <= 1'b1;
                end else begin
                    ev_data <= 1'b1;
                end
            end
        end else if (state != ST_IDLE) begin
            if (scl_rise) begin
                if (!in_ack && bitcnt < 4'h8) begin
                    shift <= {shift[6:0], sda_s};
                    bitcnt <= bitcnt + 4'h1;
                end else if (in_ack && state == ST_TX) begin
                    master_ack <= ~sda_s;
                end
            end else if (scl_fall) begin
                if (in_ack) begin
                    in_ack <= 1'b0;
                    bitcnt <= 4'h0;
                    if (state == ST_TX && master_ack) begin
                        tx_shift <= next_tx;
                        sda_oe <= ~next_tx[7];
                        crc_feed <= 1'b1;
                        crc_byte <= next_tx;
                        if (tx_idx != 2'h3) begin
                            tx_idx <= tx_idx + 2'h1;
                        end
                        if (tx_idx == 2'h0) begin
                            rd_word <= rd_mux;
                        end
                    end else begin
                        sda_oe <= 1'b0;
                        if (state == ST_TX) begin
                            state <= ST_IGNORE;
                        end
                    end
                end else if (bitcnt == 4'h8) begin
                    in_ack <= 1'b1;
                    case (state)
                        ST_ADDR: begin
                            if (addr_match) begin
                                sda_oe <= 1'b1;
                                crc_feed <= 1'b1;
                                crc_byte <= shift;
                                if (shift[0]) begin
                                    state <= ST_TX;
                                    master_ack <= 1'b1;
                                    tx_idx <= 2'h0;
                                    is_ara <= ara_mode;
                                end else begin
                                    state <= ST_WRX;
                                end
                            end else begin
                                state <= ST_IGNORE;
                            end
                        end
                        ST_WRX: begin
                            if (!cmd_seen && cmd_len(shift) == `LEN_NONE) begin
                                ev_cmd <= 1'b1;
                                state <= ST_IGNORE;
                            end else begin
                                sda_oe <= 1'b1;
                                crc_feed <= 1'b1;
                                crc_byte <= shift;
                                if (!cmd_seen) begin
                                    cmd <= shift;
                                    cmd_seen <= 1'b1;
                                end else begin
                                    if (nbytes == 2'h0) begin
                                        wdata[7:0] <= shift;
                                    end else if (nbytes == 2'h1) begin
                                        wdata[15:8] <= shift;
                                    end
                                    if (nbytes != 2'h3) begin
                                        nbytes <= nbytes + 2'h1;
                                    end
                                end
                            end
                        end
                        default: sda_oe <= 1'b0;
                    endcase
                end else if (state == ST_TX) begin
                    sda_oe <= ~tx_shift[3'h7 - bitcnt[2:0]];
                end
            end
        end
    end
end

// Sticky status flags; an event in the clearing cycle survives
always @(posedge clk or posedge rst) begin
    if (rst) begin
        temp_fault <= 1'b0;
        temp_warn <= 1'b0;
        comm_cmd <= 1'b0;
        comm_data <= 1'b0;
        comm_pec <= 1'b0;
    end else if (ce) begin
        temp_fault <= (temp_fault & ~clear_req) | overtemp_fault_event;
        temp_warn <= (temp_warn & ~clear_req) | overtemp_warning_event;
        comm_cmd <= (comm_cmd & ~clear_req) | ev_cmd;
        comm_data <= (comm_data & ~clear_req) | ev_data;
        comm_pec <= (comm_pec & ~clear_req) | ev_pec;
    end
end

// Configuration and calibration registers
always @(posedge clk or posedge rst) begin
    if (rst) begin
        module_name <= MODULE_NAME;
        lock <= `LOCK_RST;
        vout_gain <= `GAIN_RST;
        vin_gain <= `GAIN_RST;
        iout_gain <= `GAIN_RST;
        vout_ofs <= `VOUT_OFS_RST;
        vin_ofs <= `LIN_OFS_RST;
        iout_ofs <= `LIN_OFS_RST;
        pin_cfg <= `PIN_CFG_RST;
        onoff_logic <= `ONOFF_LOGIC_RST;
        ok_pol <= `OK_POL_RST;
    end else if (ce && commit) begin
        case (cmd)
            `CMD_TYPE_LOCK: begin
                module_name <= wdata[`NAME_MSB:`NAME_LSB];
                lock <= wdata[`LOCK_BIT];
            end
            `CMD_VOUT_GAIN: vout_gain <= wdata;
            `CMD_VOUT_OFS: vout_ofs <= wdata;
            `CMD_VIN_GAIN: vin_gain <= wdata;
            `CMD_VIN_OFS: vin_ofs <= wdata;
            `CMD_IOUT_GAIN: iout_gain <= wdata;
            `CMD_IOUT_OFS: iout_ofs <= wdata;
            `CMD_PIN_CFG: pin_cfg <= {3'h0, wdata[`ARA_BIT:0]};
            `CMD_ONOFF_LOGIC: onoff_logic <= {6'h00, wdata[1:0]};
            `CMD_OUTPUT_OK_SIGNAL_POL: ok_pol <= {7'h00, wdata[`OK_POL_BIT]};
            default: lock <= lock;
        endcase
    end
end

// Pin functions and output control
wire sec_raw = (pin_code == `PIN_TRIM_AUX) ? aux_s : trim_s;
wire sec_on = onoff_logic[`SEC_POL_BIT] ? sec_raw : ~sec_raw;
wire sec_ok = ~onoff_logic[`COMBINE_BIT] | (pin_code == `PIN_TRIM) |
              sec_on;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        power_stage_enable <= 1'b0;
        output_ok_signal <= 1'b0;
        trim_select <= 1'b0;
    end else if (ce) begin
        power_stage_enable <= primary_on_request & sec_ok;
        output_ok_signal <= ok_pol[`OK_POL_BIT] ? power_ok : ~power_ok;
        trim_select <= (pin_code != `PIN_SEC_ONOFF);
    end
end

endmodule // pmbus_status_mfr_config_bank

`default_nettype wire

// ---- test/pmbus_bank_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module pmbus_bank_props (
    input wire clk,
    input wire rst,
    input wire scl_pin,
    input wire sda_oe,
    input wire load_share_option,
    input wire primary_on_request,
    input wire power_ok,
    input wire power_stage_enable,
    input wire output_ok_signal,
    input wire trim_select
);
    logic scl_d;
    logic [7:0] fall_age;
    // Clocks since the bus clock pin last fell, saturating
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_d <= 1'b1;
            fall_age <= 8'hFF;
        end else begin
            scl_d <= scl_pin;
            if (scl_d && !scl_pin)
                fall_age <= 8'h00;
            else if (fall_age != 8'hFF)
                fall_age <= fall_age + 8'h01;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_bus_idle;
        scl_pin && $past(scl_pin, 8);
    endsequence
    sequence s_pok_moved;
        $past(power_ok) != $past(power_ok, 2);
    endsequence
    a_drive_after_fall: assert property (
        $changed(sda_oe) |-> fall_age inside {[8'h02:8'h08]})
        else $error("drive off fall");
    a_drive_bounded: assert property (
        $rose(sda_oe) |-> ##[1:200] !sda_oe)
        else $error("drive too long");
    a_enable_needs_primary: assert property (
        !primary_on_request [*3] |-> !power_stage_enable)
        else $error("enable no primary");
    a_enable_rise_cause: assert property (
        $rose(power_stage_enable) |-> $past(primary_on_request))
        else $error("enable rose alone");
    a_trim_at_stop: assert property (
        $changed(trim_select) |-> s_bus_idle)
        else $error("trim in frame");
    a_trim_share_lock: assert property (
        $rose(trim_select) |-> !load_share_option)
        else $error("trim with share");
    a_ok_cause: assert property (
        $changed(output_ok_signal) |-> s_pok_moved or s_bus_idle)
        else $error("ok moved alone");
    a_ok_after_reset: assert property (
        $past(rst) && power_ok |-> ##2 output_ok_signal)
        else $error("ok polarity");
endmodule // pmbus_bank_props
bind pmbus_status_mfr_config_bank pmbus_bank_props u_pmbus_bank_props (.*);
`default_nettype wire

// ---- test/host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_model #(
    parameter logic [6:0] ADDR = 7'h00
) (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_pull
);
    logic last = 1'b1;
    logic [7:0] q;
    logic a;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task step(input logic c, input logic d);
        @(posedge clk);
        scl <= c;
        sda_pull <= !d;
        repeat (3) @(posedge clk);
    endtask
    // Data only moves while the clock is low
    task bit_x(input logic b, output logic v);
        step(1'b0, last);
        step(1'b0, b);
        step(1'b1, b);
        @(negedge clk) v = sda_wire;
        step(1'b1, b);
        last = b;
    endtask
    task byte_x(input logic [7:0] d, input logic m);
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], q[i]);
        bit_x(m, a);
    endtask
    task start;
        step(1'b0, last);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        last = 1'b0;
    endtask
    task stop;
        step(1'b0, last);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        last = 1'b1;
        repeat (12) @(posedge clk);
    endtask
    function automatic int len(input logic [7:0] c);
        if (c == 8'h03)
            return 0;
        return (c == 8'h7D || c == 8'h7E || c >= 8'hE0) ? 1 : 2;
    endfunction
    task wr(input logic [7:0] c, input logic [15:0] d);
        start();
        byte_x({ADDR, 1'b0}, 1'b1);
        byte_x(c, 1'b1);
        if (len(c) > 0)
            byte_x(d[7:0], 1'b1);
        if (len(c) > 1)
            byte_x(d[15:8], 1'b1);
        stop();
    endtask
    task rd(input logic [7:0] c, output logic [15:0] d);
        d = 16'h0000;
        start();
        byte_x({ADDR, 1'b0}, 1'b1);
        byte_x(c, 1'b1);
        start();
        byte_x({ADDR, 1'b1}, 1'b1);
        byte_x(8'hFF, len(c) == 1);
        d[7:0] = q;
        if (len(c) == 2) begin
            byte_x(8'hFF, 1'b1);
            d[15:8] = q;
        end
        stop();
    endtask
endmodule // host_model
`default_nettype wire

// ---- test/pmbus_status_mfr_config_bank_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module pmbus_status_mfr_config_bank_bench;
    localparam logic [6:0] ADDR = 7'h2A;
    localparam logic [15:0] FW = 16'h0123;
    // Arbitrary module designation
    localparam logic [5:0] NAME = 6'h2C;
    logic clk = 1'b0, rst = 1'b1, pok = 1'b1, pri = 1'b1;
    logic tpin = 1'b0, apin = 1'b0, ls = 1'b0, ft = 1'b0, fw = 1'b0, al = 1'b0;
    logic [15:0] vin = 16'h0000, vout = 16'h0000;
    logic [15:0] iout = 16'h0000, temp = 16'h0000;
    logic scl, pull;
    wire sda_oe, sda_out, pse, ok, trim;
    wire sda = !(pull || sda_oe);
    integer seed = 32'h8D7A4637, mismatches = 0, checks = 0;
    always #5 clk = ~clk;
    pmbus_status_mfr_config_bank #(.FW_REVISION(FW), .MODULE_NAME(NAME))
        u_pmbus_status_mfr_config_bank (.clk(clk), .rst(rst), .ce(1'b1),
        .scl_pin(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .bus_addr_strap(ADDR), .load_share_option(ls), .alert_active(al),
        .overtemp_fault_event(ft), .overtemp_warning_event(fw),
        .vin_meas(vin), .vout_meas(vout), .iout_meas(iout),
        .temp_meas(temp), .primary_on_request(pri), .power_ok(pok),
        .trim_control_pin(tpin), .auxiliary_control_pin(apin),
        .power_stage_enable(pse), .output_ok_signal(ok),
        .trim_select(trim));
    host_model #(.ADDR(ADDR)) u_host_model (.clk(clk), .sda_wire(sda),
        .scl(scl), .sda_pull(pull));
    task summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task rc(input logic [7:0] c, input logic [15:0] exp);
        logic [15:0] v;
        u_host_model.rd(c, v);
        check(v, exp);
    endtask
    function automatic logic [15:0] gain_exp(input logic [15:0] g, p);
        return (g >= 16'h1999 && g <= 16'h2666) ? g : p;
    endfunction
    initial begin
        #600000;
        mismatches = mismatches + 1;
        summarize();
    end
    initial begin
        logic [15:0] g, p;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (12) @(posedge clk);
        check(16'(pse), 16'h0001);
        check(16'(ok), 16'h0001);
        rc(8'hE0, 16'h0000);
        rc(8'hE1, 16'h0000);
        rc(8'hE2, 16'h0001);
        rc(8'hD0, {8'h00, NAME, 2'b10});
        repeat (3) begin
            {vin, vout} <= $random(seed);
            {iout, temp} <= $random(seed);
            apin <= 1'($random(seed));
            @(posedge clk);
            rc(8'h88, vin);
            rc(8'h8B, vout);
            rc(8'h8C, iout);
            rc(8'h8D, temp);
        end
        ft <= 1'b1;
        @(posedge clk);
        ft <= 1'b0;
        rc(8'h7D, 16'h0080);
        fw <= 1'b1;
        @(posedge clk);
        fw <= 1'b0;
        rc(8'h7D, 16'h00C0);
        u_host_model.wr(8'h03, 16'h0000);
        rc(8'h7D, 16'h0000);
        $display("status test done");
        u_host_model.wr(8'hD1, 16'h2100);
        rc(8'hD1, 16'h2000);
        rc(8'h7E, 16'h0040);
        u_host_model.wr(8'hD0, {8'h00, NAME, 2'b00});
        rc(8'hD0, {8'h00, NAME, 2'b00});
        p = 16'h2000;
        for (int i = 0; i < 6; i++) begin
            g = 16'h1999 + 16'({$random(seed)} % 32'h0CCE);
            g = (i == 0) ? 16'h2667 : (i == 1) ? 16'h1999 : g;
            g = (i == 2) ? 16'h1998 : (i == 3) ? 16'h2666 : g;
            u_host_model.wr(8'hD3, g);
            p = gain_exp(g, p);
            rc(8'hD3, p);
        end
        u_host_model.wr(8'hD2, 16'hA0AB);
        rc(8'hD2, 16'hA0AB);
        u_host_model.wr(8'hD4, 16'hE955);
        rc(8'hD4, 16'hE955);
        u_host_model.wr(8'hD7, 16'hA0AB);
        rc(8'hD7, 16'hE800);
        u_host_model.wr(8'h03, 16'h0000);
        u_host_model.wr(8'hDB, 16'h1234);
        rc(8'hDB, FW);
        rc(8'h7E, 16'h0080);
        $display("calibration test done");
        u_host_model.wr(8'hE1, 16'h00FF);
        rc(8'hE1, 16'h0003);
        check(16'(pse), 16'h0000);
        tpin <= 1'b1;
        repeat (10) @(posedge clk);
        check(16'(pse), 16'h0001);
        pri <= 1'b0;
        repeat (4) @(posedge clk);
        check(16'(pse), 16'h0000);
        u_host_model.wr(8'hE2, 16'h00FE);
        rc(8'hE2, 16'h0000);
        pok <= 1'b0;
        repeat (4) @(posedge clk);
        check(16'(ok), 16'h0001);
        u_host_model.wr(8'hE0, 16'h0010);
        al <= 1'b1;
        rc(8'hE0, 16'h00FF);
        al <= 1'b0;
        rc(8'hE0, 16'h0010);
        for (int c = 2; c >= 0; c--) begin
            u_host_model.wr(8'hE0, 16'h00E0 | 16'(c));
            rc(8'hE0, 16'(c));
            check(16'(trim), 16'(c != 0));
        end
        ls <= 1'b1;
        u_host_model.wr(8'hE0, 16'h0001);
        rc(8'hE0, 16'h0000);
        $display("config test done");
        summarize();
    end
endmodule // pmbus_status_mfr_config_bank_bench
`default_nettype wire
